// ==== verilog/hsf_pkg.sv ====
// Package: shared types and timing constants for the hot swap fault supervisor
package hsf_pkg;

   // Drain-source short check time, in microseconds, and its cycle count
   localparam int unsigned CLK_PERIOD_NS        = 25;
   localparam int unsigned DS_CHECK_TIME_US     = 100;
   localparam int unsigned DS_CHECK_CYCLES      =
      (DS_CHECK_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned DS_CNT_W             = 20;

   // Power-on delay after the regulator is valid, in microseconds
   localparam int unsigned POR_TIME_US          = 500;
   localparam int unsigned POR_CYCLES           =
      (POR_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned POR_CNT_W            = 20;

   // One-bit comparator results from the analog front end
   typedef struct packed {
      logic reg_uv_high;    // Regulator above undervoltage-high level
      logic reg_uv_low;     // Regulator below undervoltage-low level
      logic retry_high;     // Retry node above retry_high_level
      logic retry_low;      // Retry node below retry_low_level
      logic gate_fault;     // Gate monitor above gate_fault_level
      logic source_fault;   // Source monitor above source_fault_level
      logic sense_short;    // Sense drop below half of (FET drop - offset)
      logic gate_drive_good;// Gate-source above gate_drive_good_level
   } hsf_cmp_s;

   // Trip requests from the protection front end
   typedef struct packed {
      logic primary_oc;     // Primary overcurrent persisted its time
      logic secondary_oc;   // Secondary overcurrent detected
      logic uvlo;           // Input undervoltage lockout
      logic ovp;            // Overvoltage
      logic open_load_sense;
      logic open_ground_sense;
   } hsf_trip_s;

   // Analog actuator controls
   typedef struct packed {
      logic gate_drive_en;  // Gate charge pump on
      logic gate_strong_pd; // Fault-mode strong gate pull-down
      logic gate_weak_pd;   // Weak gate sink
      logic retry_sink_en;  // Strong sink on retry_timing_node
      logic retry_src_en;   // Weak charge source on retry_timing_node
      logic slope_gate_mode;// Gate voltage slope control for inrush
   } hsf_drive_s;

   typedef enum logic [2:0] {
      HSF_ST_OFF     = 3'b000,
      HSF_ST_RUN     = 3'b001,
      HSF_ST_TRIPPED = 3'b010,
      HSF_ST_RECOVER = 3'b011,
      HSF_ST_HWFAULT = 3'b100
   } hsf_state_e;

endpackage : hsf_pkg

// ==== verilog/hsf_sticky.sv ====
// Sticky fault latch that only a regulator undervoltage clears
`timescale 1ns/1ps
module hsf_sticky (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   logic flag_d;
   logic flag_q;

   // Set wins over clear
   always_comb begin
      flag_d = flag_q;
      if (set_i) begin
         flag_d = 1'b1;
      end else if (clr_i) begin
         flag_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;
endmodule : hsf_sticky

// ==== verilog/hsf_timer.sv ====
// Down counter that raises done when a load-started interval elapses
`timescale 1ns/1ps
module hsf_timer #(
   parameter int unsigned W     = 20,
   parameter int unsigned COUNT = 4000
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic start_i,
   input  wire logic stop_i,
   output logic      done_o
);
   logic [W-1:0] cnt_d;
   logic [W-1:0] cnt_q;
   logic         run_d;
   logic         run_q;
   logic         done_d;
   logic         done_q;

   always_comb begin
      cnt_d  = cnt_q;
      run_d  = run_q;
      done_d = 1'b0;
      if (stop_i) begin
         run_d = 1'b0;
      end else if (start_i) begin
         cnt_d = W'(COUNT - 1);
         run_d = 1'b1;
      end else if (run_q) begin
         if (cnt_q == '0) begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end else begin
            cnt_d = cnt_q - W'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         run_q  <= run_d;
         done_q <= done_d;
      end
   end

   assign done_o = done_q;
endmodule : hsf_timer

// ==== verilog/hsf_supervisor.sv ====
// Top: breaker auto-retry sequencer and damaged-part fault detectors
// Behaviour
// RQ1 - Primary overcurrent trip: gate off, strong pull-down, discharge, fault
// RQ2 - Breaker not tripped: strong sink holds retry node at ground
// RQ3 - On trip: release sink, charge retry node weakly, start retry
// RQ4 - Retry node high: reset breaker, clear current fault, discharge node
// RQ5 - Retry node low: re-enable gate drive, discharge output low
// RQ6 - Secondary overcurrent retries exactly like primary
// RQ7 - Persistent overcurrent repeats start, trip, retry, restart forever
// RQ8 - Gate monitor crossing with supply, POR done, enable low: hardware fault
// RQ9 - Source monitor crossing under same conditions: hardware fault, no timer
// RQ10 - Gate/source latches clear only on regulator undervoltage-low
// RQ11 - Enable fall after steady state: gate off, weak sink, discharge, timer
// RQ12 - Source still high at timer end: hardware fault till power removal
// RQ13 - Any listed fault: gate off, pull-down, discharge, timer, monitor
// RQ14 - Sense-short detect armed after enable rise, POR, gate drive good
// RQ15 - Shorted sense resistor: switch inrush to gate voltage slope control
// RQ16 - Sense-short flag comes from the offset comparator input
// RQ17 - Sense short: internal trip, gate off, pull-down, discharge, fault
// RQ18 - Processor removes supply to clear a sense-resistor fault
// RQ19 - Comparators are one-bit inputs; each detector has its own latch
`timescale 1ns/1ps
module hsf_supervisor
   import hsf_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              enable_i,
   input  wire hsf_pkg::hsf_cmp_s  cmp_i,
   input  wire hsf_pkg::hsf_trip_s trip_i,
   output hsf_pkg::hsf_drive_s     drive_o,
   output logic                   discharge_out_o,
   output logic                   current_fault_out_o,
   output logic                   hardware_fault_out_o,
   output logic                   steady_state_o
);
   import hsf_pkg::*;

   hsf_state_e st_d;
   hsf_state_e st_q;
   logic       reg_ok_d;
   logic       reg_ok_q;
   logic       en_d;
   logic       en_q;
   logic       arm_d;
   logic       arm_q;
   logic       steady_d;
   logic       steady_q;
   hsf_drive_s drv_d;
   hsf_drive_s drv_q;
   logic       discharge_out_d;
   logic       discharge_out_q;
   logic       ifault_d;
   logic       ifault_q;
   logic       ds_mon_d;
   logic       ds_mon_q;

   logic por_done;
   logic por_start;
   logic ds_start;
   logic ds_done;
   logic uv_clear;
   logic en_rise;
   logic en_fall;
   logic any_trip;
   logic oc_trip;
   logic idle_check;
   logic gate_flt;
   logic src_flt;
   logic ds_flt;
   logic rs_flt;
   logic por_flag;
   logic gate_set;
   logic src_set;
   logic ds_set;
   logic rs_set;
   logic hw_d;
   logic hw_q;

   assign uv_clear = cmp_i.reg_uv_low; // RQ10
   assign en_rise  = enable_i & ~en_q;
   assign en_fall  = ~enable_i & en_q;
   assign oc_trip  = trip_i.primary_oc | trip_i.secondary_oc; // RQ6
   assign any_trip = oc_trip | trip_i.uvlo | trip_i.ovp |
                     trip_i.open_load_sense | trip_i.open_ground_sense; // RQ13
   assign por_start = cmp_i.reg_uv_high & ~reg_ok_q;
   // Gate and source were driven until this edge, so it is skipped
   assign idle_check = reg_ok_q & por_flag & ~enable_i &
                       (st_q != HSF_ST_RUN); // RQ8
   // Supply loss masks every detector so its clear always wins
   assign gate_set = ~uv_clear & idle_check & cmp_i.gate_fault; // RQ8
   // Idle source check waits while the post-run window owns the node
   assign src_set  = ~uv_clear & idle_check & ~ds_mon_q &
                     cmp_i.source_fault; // RQ9
   assign ds_set   = ~uv_clear & ds_done & ds_mon_q &
                     cmp_i.source_fault; // RQ12
   assign rs_set   = ~uv_clear & arm_q & cmp_i.sense_short; // RQ16

   // Power-on delay runs once the regulator is valid
   hsf_timer #(.W(POR_CNT_W), .COUNT(POR_CYCLES)) u_por (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .start_i (por_start),
      .stop_i  (uv_clear),
      .done_o  (por_done)
   );

   hsf_sticky u_por_flag (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .set_i  (por_done),
      .clr_i  (uv_clear),
      .flag_o (por_flag)
   );

   // Drain-source check timer
   hsf_timer #(.W(DS_CNT_W), .COUNT(DS_CHECK_CYCLES)) u_ds (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .start_i (ds_start),
      .stop_i  (uv_clear),
      .done_o  (ds_done)
   );

   // Separate latches per detector
   hsf_sticky u_gate_flt ( // RQ19
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .set_i  (gate_set),
      .clr_i  (uv_clear),
      .flag_o (gate_flt)
   );

   hsf_sticky u_src_flt (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .set_i  (src_set),
      .clr_i  (uv_clear),
      .flag_o (src_flt)
   );

   hsf_sticky u_ds_flt (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .set_i  (ds_set),
      .clr_i  (uv_clear),
      .flag_o (ds_flt)
   );

   hsf_sticky u_rs_flt (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .set_i  (rs_set),
      .clr_i  (uv_clear), // RQ18
      .flag_o (rs_flt)
   );

   always_comb begin
      st_d     = st_q;
      reg_ok_d = reg_ok_q;
      en_d     = enable_i;
      arm_d    = arm_q;
      steady_d = steady_q;
      discharge_out_d  = discharge_out_q;
      ifault_d = ifault_q;
      ds_mon_d = ds_mon_q;
      ds_start = 1'b0;
      drv_d    = drv_q;
      drv_d.slope_gate_mode = rs_flt; // RQ15
      // Mirrors the four latches so the pin comes from a flop
      hw_d     = ~uv_clear & (gate_flt | src_flt | ds_flt | rs_flt |
                              gate_set | src_set | ds_set | rs_set); // RQ10

      if (cmp_i.reg_uv_high) begin
         reg_ok_d = 1'b1;
      end
      if (ds_done) begin
         ds_mon_d = 1'b0;
      end

      // Arm the sense-short detector only once fully started
      // Disarmed off the run state: low drain current gives false shorts
      if (en_rise || en_fall || st_q != HSF_ST_RUN) begin
         arm_d = 1'b0;
      end
      if (enable_i && por_flag && cmp_i.gate_drive_good &&
          st_q == HSF_ST_RUN) begin
         arm_d = 1'b1; // RQ14
      end

      case (st_q)
         HSF_ST_OFF: begin
            drv_d.retry_sink_en = 1'b1; // RQ2
            drv_d.retry_src_en  = 1'b0;
            if (por_flag && enable_i && !rs_flt && !any_trip) begin
               st_d                 = HSF_ST_RUN; // RQ7
               drv_d.gate_drive_en  = 1'b1;
               drv_d.gate_strong_pd = 1'b0;
               drv_d.gate_weak_pd   = 1'b0;
               discharge_out_d              = 1'b0;
            end
         end
         HSF_ST_RUN: begin
            if (cmp_i.gate_drive_good) begin
               steady_d = 1'b1;
            end
            if (arm_q && cmp_i.sense_short) begin
               st_d                 = HSF_ST_HWFAULT; // RQ17
               drv_d.gate_drive_en  = 1'b0;
               drv_d.gate_strong_pd = 1'b1;
               discharge_out_d              = 1'b1;
               steady_d             = 1'b0;
            end else if (any_trip) begin
               st_d                 = oc_trip ? HSF_ST_TRIPPED : HSF_ST_OFF;
               drv_d.gate_drive_en  = 1'b0; // RQ1
               drv_d.gate_strong_pd = 1'b1;
               discharge_out_d              = 1'b1;
               ifault_d             = oc_trip;
               drv_d.retry_sink_en  = ~oc_trip; // RQ3
               drv_d.retry_src_en   = oc_trip;
               ds_start             = steady_q; // RQ13
               ds_mon_d             = steady_q;
               steady_d             = 1'b0;
            end else if (!enable_i) begin
               st_d                 = HSF_ST_OFF;
               drv_d.gate_drive_en  = 1'b0; // RQ11
               drv_d.gate_weak_pd   = 1'b1;
               discharge_out_d              = 1'b1;
               ds_start             = steady_q;
               ds_mon_d             = steady_q;
               steady_d             = 1'b0;
            end
         end
         HSF_ST_TRIPPED: begin
            if (cmp_i.retry_high) begin
               st_d                = HSF_ST_RECOVER; // RQ4
               ifault_d            = 1'b0;
               drv_d.retry_src_en  = 1'b0;
               drv_d.retry_sink_en = 1'b1;
            end
         end
         HSF_ST_RECOVER: begin
            if (cmp_i.retry_low) begin
               st_d                 = HSF_ST_OFF; // RQ5
               discharge_out_d              = 1'b0;
               drv_d.gate_strong_pd = 1'b0;
               drv_d.gate_weak_pd   = 1'b1;
            end
         end
         HSF_ST_HWFAULT: begin
            // Held until power is removed
         end
         default: begin
            st_d = HSF_ST_OFF;
         end
      endcase

      if (uv_clear) begin
         st_d     = HSF_ST_OFF;
         reg_ok_d = 1'b0;
         arm_d    = 1'b0;
         steady_d = 1'b0;
         ifault_d = 1'b0;
         discharge_out_d  = 1'b0;
         ds_mon_d = 1'b0;
         drv_d    = '{gate_drive_en: 1'b0, gate_strong_pd: 1'b0,
                      gate_weak_pd: 1'b1, retry_sink_en: 1'b1,
                      retry_src_en: 1'b0, slope_gate_mode: 1'b0};
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q     <= HSF_ST_OFF;
         reg_ok_q <= 1'b0;
         en_q     <= 1'b0;
         arm_q    <= 1'b0;
         steady_q <= 1'b0;
         discharge_out_q  <= 1'b0;
         ifault_q <= 1'b0;
         ds_mon_q <= 1'b0;
         hw_q     <= 1'b0;
         drv_q    <= '{gate_drive_en: 1'b0, gate_strong_pd: 1'b0,
                       gate_weak_pd: 1'b1, retry_sink_en: 1'b1,
                       retry_src_en: 1'b0, slope_gate_mode: 1'b0};
      end else begin
         st_q     <= st_d;
         reg_ok_q <= reg_ok_d;
         en_q     <= en_d;
         arm_q    <= arm_d;
         steady_q <= steady_d;
         discharge_out_q  <= discharge_out_d;
         ifault_q <= ifault_d;
         ds_mon_q <= ds_mon_d;
         hw_q     <= hw_d;
         drv_q    <= drv_d;
      end
   end

   assign drive_o              = drv_q;
   assign discharge_out_o      = discharge_out_q;
   assign current_fault_out_o  = ifault_q;
   assign hardware_fault_out_o = hw_q;
   assign steady_state_o       = steady_q;
endmodule : hsf_supervisor

// ==== sim/hsf_supervisor_asserts.sv ====
// Checker: timing relations on the supervisor ports
`timescale 1ns/1ps
module hsf_sup_asserts
   import hsf_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rstn_i,
   input  wire logic               enable_i,
   input  wire hsf_pkg::hsf_cmp_s  cmp_i,
   input  wire hsf_pkg::hsf_trip_s trip_i,
   input  wire hsf_pkg::hsf_drive_s drive_o,
   input  wire logic               discharge_out_o,
   input  wire logic               current_fault_out_o,
   input  wire logic               hardware_fault_out_o,
   input  wire logic               steady_state_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   chk_poc_trip: assert property (drive_o.gate_drive_en
      && trip_i.primary_oc |=> !drive_o.gate_drive_en
      && drive_o.gate_strong_pd && discharge_out_o && current_fault_out_o)
      else $error("overcurrent trip response wrong");
   chk_sink_idle: assert property (!current_fault_out_o
      |-> drive_o.retry_sink_en && !drive_o.retry_src_en)
      else $error("retry node not held low");
   chk_trip_charge: assert property ($rose(current_fault_out_o)
      |-> drive_o.retry_src_en && !drive_o.retry_sink_en)
      else $error("retry node not charging after trip");
   chk_retry_reset: assert property (current_fault_out_o
      && cmp_i.retry_high |=> !current_fault_out_o && drive_o.retry_sink_en)
      else $error("breaker not reset at retry high");
   chk_gate_hold: assert property ($fell(current_fault_out_o)
      && !$past(cmp_i.reg_uv_low)
      |-> discharge_out_o && !drive_o.gate_drive_en)
      else $error("gate back before retry low");
   chk_hw_sticky: assert property (hardware_fault_out_o
      && !cmp_i.reg_uv_low |=> hardware_fault_out_o)
      else $error("hardware fault dropped");
   chk_hw_clear: assert property (cmp_i.reg_uv_low
      |=> !hardware_fault_out_o)
      else $error("hardware fault survived power loss");
   chk_enable_fall: assert property (steady_state_o
      && drive_o.gate_drive_en && $fell(enable_i) && trip_i == '0
      && !cmp_i.sense_short |=> !drive_o.gate_drive_en
      && drive_o.gate_weak_pd && discharge_out_o)
      else $error("enable fall response wrong");
   chk_sense_trip: assert property (steady_state_o
      && drive_o.gate_drive_en && cmp_i.sense_short |-> ##[1:2]
      (hardware_fault_out_o && drive_o.gate_strong_pd && discharge_out_o))
      else $error("sense short not tripped");

   cover property ($rose(current_fault_out_o));
   cover property ($rose(hardware_fault_out_o));
   cover property ($fell(enable_i) && steady_state_o);
endmodule : hsf_sup_asserts

bind hsf_supervisor hsf_sup_asserts u_chk (
   .clk_i               (clk_i),
   .rstn_i              (rstn_i),
   .enable_i            (enable_i),
   .cmp_i               (cmp_i),
   .trip_i              (trip_i),
   .drive_o             (drive_o),
   .discharge_out_o     (discharge_out_o),
   .current_fault_out_o (current_fault_out_o),
   .hardware_fault_out_o(hardware_fault_out_o),
   .steady_state_o      (steady_state_o)
);

// ==== sim/hsf_proc_model.sv ====
// Partner: supply rail and retry timing node behind the supervisor
`timescale 1ns/1ps
module hsf_proc_model
   import hsf_pkg::*;
#(
   parameter int unsigned RETRY_TOP = 16
) (
   input  wire logic                clk_i,
   input  wire logic                pwr_on_i,
   input  wire hsf_pkg::hsf_drive_s drive_i,
   output logic                     reg_uv_high_o,
   output logic                     reg_uv_low_o,
   output logic                     retry_high_o,
   output logic                     retry_low_o
);
   logic pwr_q;
   int   node_q;

   initial begin
      pwr_q  = 1'b0;
      node_q = 0;
   end
   // Only a supply removal clears latched hardware faults
   assign reg_uv_high_o = pwr_q;
   assign reg_uv_low_o  = !pwr_q;
   assign retry_high_o  = node_q >= RETRY_TOP;
   assign retry_low_o   = node_q < 2;
   // Weak source climbs slowly, strong sink drains fast
   always @(posedge clk_i) begin
      pwr_q <= pwr_on_i;
      if (!pwr_on_i) begin
         node_q <= 0;
      end else if (drive_i.retry_src_en) begin
         node_q <= node_q + 1;
      end else if (drive_i.retry_sink_en) begin
         node_q <= (node_q > 4) ? node_q - 4 : 0;
      end
   end
endmodule : hsf_proc_model

// ==== sim/test_hot_swap_fault_supervisor.sv ====
// Testbench: auto-retry, sense short and damaged transistor scenarios
`timescale 1ns/1ps
module test_hot_swap_fault_supervisor;
   import hsf_pkg::*;
   logic       clk_i  = 1'b0;
   logic       rstn_i = 1'b0;
   logic       enable, pwr_on, uvh, uvl, rhi, rlo;
   logic       gate_flt, src_flt, sns_short, gate_good;
   logic       dis, cur_flt, hardware_fault_out, steady;
   hsf_cmp_s   cmp;
   hsf_trip_s  trip;
   hsf_drive_s drv;
   int         errors     = 0;
   int         num_checks = 0;
   int         n;

   assign cmp = '{uvh, uvl, rhi, rlo, gate_flt, src_flt, sns_short, gate_good};
   always #12.5 clk_i = ~clk_i;

   hsf_supervisor i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .enable_i(enable),
      .cmp_i(cmp), .trip_i(trip), .drive_o(drv), .discharge_out_o(dis),
      .current_fault_out_o(cur_flt), .hardware_fault_out_o(hardware_fault_out),
      .steady_state_o(steady));
   hsf_proc_model i_proc (.clk_i(clk_i), .pwr_on_i(pwr_on), .drive_i(drv),
      .reg_uv_high_o(uvh), .reg_uv_low_o(uvl), .retry_high_o(rhi),
      .retry_low_o(rlo));

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wait_gate(input int lim);
      for (n = 0; n < lim && drv.gate_drive_en !== 1'b1; n++) @(negedge clk_i);
   endtask : wait_gate

   task automatic power_cycle;
      pwr_on = 1'b0;
      repeat (4) @(negedge clk_i);
      check(hardware_fault_out === 1'b0, "fault kept after power loss");
      pwr_on = 1'b1;
   endtask : power_cycle

   task automatic one_retry(input logic sec);
      trip.primary_oc   = ~sec;
      trip.secondary_oc = sec;
      for (n = 0; n < 20 && cur_flt !== 1'b1; n++) @(negedge clk_i);
      // Gate is off now, so the overcurrent request goes away
      trip = '0;
      check(cur_flt === 1'b1 && drv.gate_drive_en === 1'b0, "no trip");
      check(drv.gate_strong_pd === 1'b1 && dis === 1'b1, "no pull-down");
      check(drv.retry_src_en === 1'b1 && drv.retry_sink_en === 1'b0, "no charge");
      for (n = 0; n < 100 && cur_flt === 1'b1; n++) @(negedge clk_i);
      check(drv.retry_sink_en === 1'b1 && cur_flt === 1'b0, "no reset");
      check(drv.gate_drive_en === 1'b0 && dis === 1'b1, "early gate");
      for (n = 0; n < 20 && dis === 1'b1; n++) @(negedge clk_i);
      wait_gate(5);
      check(drv.gate_drive_en === 1'b1, "no restart");
   endtask : one_retry

   task automatic t_oc_retry;
      enable = 1'b1;
      wait_gate(POR_CYCLES + 100);
      one_retry(1'b0);
      one_retry(1'b0);
      one_retry(1'b1);
   endtask : t_oc_retry

   task automatic t_sense_short;
      sns_short = 1'b1;
      repeat (4) @(negedge clk_i);
      check(hardware_fault_out === 1'b0, "sense short before arming");
      sns_short = 1'b0;
      gate_good = 1'b1;
      repeat (4) @(negedge clk_i);
      check(steady === 1'b1 && hardware_fault_out === 1'b0, "not steady");
      sns_short = 1'b1;
      repeat (3) @(negedge clk_i);
      check(hardware_fault_out === 1'b1 && drv.gate_strong_pd === 1'b1, "missed");
      check(drv.gate_drive_en === 1'b0 && dis === 1'b1, "gate left on");
      check(drv.slope_gate_mode === 1'b1, "no gate slope mode");
      sns_short = 1'b0;
      gate_good = 1'b0;
      enable    = 1'b0;
      power_cycle();
   endtask : t_sense_short

   task automatic t_gate_idle;
      repeat (100) @(negedge clk_i);
      gate_flt = 1'b1;
      repeat (100) @(negedge clk_i);
      check(hardware_fault_out === 1'b0, "fault before power-on delay");
      repeat (POR_CYCLES) @(negedge clk_i);
      check(hardware_fault_out === 1'b1, "gate short missed");
      enable = 1'b1;
      repeat (3) @(negedge clk_i);
      enable = 1'b0;
      repeat (3) @(negedge clk_i);
      check(hardware_fault_out === 1'b1, "cleared by enable");
      gate_flt = 1'b0;
      power_cycle();
   endtask : t_gate_idle

   task automatic t_src_idle;
      repeat (100) @(negedge clk_i);
      src_flt = 1'b1;
      repeat (100) @(negedge clk_i);
      check(hardware_fault_out === 1'b0, "source fault before delay");
      repeat (POR_CYCLES) @(negedge clk_i);
      check(hardware_fault_out === 1'b1, "source short missed");
      src_flt = 1'b0;
      power_cycle();
   endtask : t_src_idle

   task automatic t_ds_steady;
      enable    = 1'b1;
      gate_good = 1'b1;
      wait_gate(POR_CYCLES + 100);
      repeat (4) @(negedge clk_i);
      trip.ovp = 1'b1;
      @(negedge clk_i);
      check(drv.gate_drive_en === 1'b0 && dis === 1'b1, "ovp gate");
      check(drv.gate_strong_pd === 1'b1 && cur_flt === 1'b0, "ovp");
      trip.ovp = 1'b0;
      wait_gate(5);
      repeat (4) @(negedge clk_i);
      src_flt = 1'b1;
      enable  = 1'b0;
      @(negedge clk_i);
      check(drv.gate_drive_en === 1'b0 && drv.gate_weak_pd === 1'b1, "gate");
      check(dis === 1'b1 && hardware_fault_out === 1'b0, "no discharge");
      repeat (DS_CHECK_CYCLES - 10) @(negedge clk_i);
      check(hardware_fault_out === 1'b0, "check timer ended early");
      repeat (20) @(negedge clk_i);
      check(hardware_fault_out === 1'b1, "drain-source short missed");
   endtask : t_ds_steady

   initial begin
      enable    = 1'b0;
      pwr_on    = 1'b0;
      gate_flt  = 1'b0;
      src_flt   = 1'b0;
      sns_short = 1'b0;
      gate_good = 1'b0;
      trip      = '0;
      repeat (16) @(negedge clk_i);
      check(drv === hsf_drive_s'(6'h0c) && hardware_fault_out === 1'b0, "reset values");
      rstn_i = 1'b1;
      pwr_on = 1'b1;
      t_oc_retry();
      t_sense_short();
      t_gate_idle();
      t_src_idle();
      t_ds_steady();
      tally_and_finish();
   end

   // Four power-on delays plus one check window dominate the run
   initial begin
      repeat (95000) @(posedge clk_i);
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule : test_hot_swap_fault_supervisor
